// [pso_pkg.sv]
// ****************************************
// Shared constants of the serializer
// ****************************************
package pso_pkg;
  // Conversion widths
  localparam logic [3:0] WIDTH_FOUR  = 4'h4;
  localparam logic [3:0] WIDTH_EIGHT = 4'h8;
  // Last bit index and half-word boundary for each width
  localparam logic [2:0] LAST_IDX_FOUR  = 3'h3;
  localparam logic [2:0] LAST_IDX_EIGHT = 3'h7;
  localparam logic [2:0] HALF_IDX_FOUR  = 3'h2;
  localparam logic [2:0] HALF_IDX_EIGHT = 3'h4;
  // Parallel bit positions used by the reduced paths
  localparam int DATA_LOW_BIT  = 0;
  localparam int DATA_HIGH_BIT = 4;
  localparam int HIZ_LOW_BIT   = 1;
  localparam int HIZ_HIGH_BIT  = 5;
  // Reset and inversion defaults
  localparam logic INIT_VALUE_DEF  = 1'h0;
  localparam logic INVERT_OFF      = 1'h0;
  // Extra load stages for each width, which sets the fixed latency
  localparam logic [1:0] LOAD_STAGES_FOUR  = 2'h0;
  localparam logic [1:0] LOAD_STAGES_EIGHT = 2'h1;
endpackage : pso_pkg

// [pso_serializer.sv]
// Operation
// - Width selectable 4 or 8, default 8, sets bits sent per slow period.
// - Single rate 2:1 or 4:1, double rate 4:1 or 8:1; no 8:1 single rate.
// - Parallel input 0 goes out first, then higher inputs in ascending order.
// - Parallel word is sampled on the fast clock and loaded on a slow clock edge; shifting runs on the fast clock.
// - Reset acts asynchronously; the driver releases it synchronously.
// - Tristate input reaches tristate output after three flops unless in bypass or emulation; high means high impedance.
// - Data flip-flops start at the configured initial value, default 0; tristate flip-flops start at 1.
// - Data bypass makes output follow input 0, else the word is serialized (inputs 0 and 4 in emulation).
// - Tristate bypass follows input 1, else emulation serializes inputs 1 and 5, else the tristate input.
// - Register emulation mode sends inputs 0 and 4 per slow clock period.
// - Fast clock, slow clock and reset each have a local inversion.
// - Latency from capture to output is fixed per width and differs.
// - No output enable, cascade, loopback or tristate byte functions.
`timescale 1ns/100ps
`default_nettype none
module pso_serializer #(
  parameter logic INIT_VALUE        = pso_pkg::INIT_VALUE_DEF,
  parameter logic FAST_CLOCK_INVERT = pso_pkg::INVERT_OFF,
  parameter logic SLOW_CLOCK_INVERT = pso_pkg::INVERT_OFF,
  parameter logic RESET_INVERT      = pso_pkg::INVERT_OFF
) (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  // Parallel side
  input  wire logic       i_slow_parallel_clock,
  input  wire logic [7:0] i_parallel_data,
  input  wire logic       i_hiz_control,
  // Configuration
  input  wire logic       i_width_eight,
  input  wire logic       i_data_path_bypass,
  input  wire logic       i_hiz_path_bypass,
  input  wire logic       i_ddr_register_emulation,
  // Pad side
  output logic            o_serial_output,
  output logic            o_hiz_output
);

  // ****************************************
  // Local clock and reset inversion
  // ****************************************
  logic       clk_int;
  logic       reset_act;
  // Constant polarity choice, so no real gating on the clock tree
  assign clk_int   = i_clock ^ FAST_CLOCK_INVERT;
  assign reset_act = i_reset ^ RESET_INVERT;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic       slow_s1_reg;
  logic       slow_s2_reg;
  logic       slow_prev_reg;
  logic [7:0] data_s1_reg;
  logic [7:0] data_s2_reg;
  logic       hiz_s1_reg;
  logic       hiz_s2_reg;
  logic       slow_level;
  logic       slow_edge;

  // Two flops on every input from the slow domain or the pins
  always_ff @(posedge clk_int or posedge reset_act)
  begin
    if (reset_act)
    begin
      slow_s1_reg <= 1'h0;
      slow_s2_reg <= 1'h0;
      data_s1_reg <= {8{INIT_VALUE}};
      data_s2_reg <= {8{INIT_VALUE}};
      hiz_s1_reg  <= 1'h1;
      hiz_s2_reg  <= 1'h1;
    end
    else
    begin
      slow_s1_reg <= i_slow_parallel_clock;
      slow_s2_reg <= slow_s1_reg;
      data_s1_reg <= i_parallel_data;
      data_s2_reg <= data_s1_reg;
      hiz_s1_reg  <= i_hiz_control;
      hiz_s2_reg  <= hiz_s1_reg;
    end
  end

  // Slow clock edge seen in the fast domain
  assign slow_level = slow_s2_reg ^ SLOW_CLOCK_INVERT;
  assign slow_edge  = slow_level & ~slow_prev_reg;

  always_ff @(posedge clk_int or posedge reset_act)
  begin
    if (reset_act)
      slow_prev_reg <= SLOW_CLOCK_INVERT;  // Idle level, so no false edge after reset
    else
      slow_prev_reg <= slow_level;
  end

  // ****************************************
  // Word capture with width dependent latency
  // ****************************************
  logic       load_late_reg;
  logic       load_word;
  logic [7:0] word_reg;
  logic [2:0] bit_cnt_reg;
  logic [2:0] bit_cnt_next;
  logic       active_reg;
  logic [2:0] last_idx;
  logic [2:0] half_idx;

  // Width 8 waits one more edge, so each width has its own fixed latency
  assign load_word = i_width_eight ? load_late_reg : slow_edge;
  assign last_idx  = i_width_eight ? pso_pkg::LAST_IDX_EIGHT
                                   : pso_pkg::LAST_IDX_FOUR;
  // Half word marks the first bit index of the upper half of each word
  assign half_idx  = i_width_eight ? pso_pkg::HALF_IDX_EIGHT
                                   : pso_pkg::HALF_IDX_FOUR;

  always_ff @(posedge clk_int or posedge reset_act)
  begin
    if (reset_act)
      load_late_reg <= 1'h0;
    else
      load_late_reg <= slow_edge;
  end

  // Bit index stops on the last bit if the slow clock is late
  always_comb
  begin
    bit_cnt_next = bit_cnt_reg;
    if (load_word)
      bit_cnt_next = 3'h0;
    else if (active_reg && bit_cnt_reg != last_idx)
      bit_cnt_next = bit_cnt_reg + 3'h1;
  end

  always_ff @(posedge clk_int or posedge reset_act)
  begin
    if (reset_act)
    begin
      word_reg    <= {8{INIT_VALUE}};
      bit_cnt_reg <= 3'h0;
      active_reg  <= 1'h0;
    end
    else
    begin
      bit_cnt_reg <= bit_cnt_next;
      if (load_word)
      begin
        word_reg   <= data_s2_reg;
        active_reg <= 1'h1;
      end
    end
  end

  // ****************************************
  // Output paths
  // ****************************************
  logic       serial_next;
  logic       hiz_next;
  logic       upper_half;

  assign upper_half = (bit_cnt_reg >= half_idx);

  // Data path: bypass, register emulation pair, or full serial word
  always_comb
  begin
    serial_next = INIT_VALUE;
    if (i_data_path_bypass)
      serial_next = data_s2_reg[pso_pkg::DATA_LOW_BIT];
    else if (!active_reg)
      serial_next = INIT_VALUE;
    else if (i_ddr_register_emulation)
      serial_next = upper_half ? word_reg[pso_pkg::DATA_HIGH_BIT]
                               : word_reg[pso_pkg::DATA_LOW_BIT];
    else
      serial_next = word_reg[bit_cnt_reg];
  end

  // Tristate path; the plain path costs one flop so the pad sees a clean edge
  always_comb
  begin
    hiz_next = hiz_s2_reg;
    if (i_hiz_path_bypass)
      hiz_next = data_s2_reg[pso_pkg::HIZ_LOW_BIT];
    else if (i_ddr_register_emulation)
      hiz_next = upper_half ? word_reg[pso_pkg::HIZ_HIGH_BIT]
                            : word_reg[pso_pkg::HIZ_LOW_BIT];
    else
      hiz_next = hiz_s2_reg;
  end

  // No enable, cascade or loopback ports exist on purpose
  always_ff @(posedge clk_int or posedge reset_act)
  begin
    if (reset_act)
    begin
      o_serial_output <= INIT_VALUE;
      o_hiz_output    <= 1'h1;
    end
    else
    begin
      o_serial_output <= serial_next;
      o_hiz_output    <= hiz_next;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  // Outputs are flops, so most checks look one edge after the values that feed them
  AST_RESET_INIT: assert property (@(posedge clk_int)
    reset_act |=> o_serial_output == INIT_VALUE)
    else $error("output not at initial value after reset");

  AST_LOAD_RESTART: assert property (@(posedge clk_int) disable iff (reset_act)
    load_word |=> bit_cnt_reg == 3'h0)
    else $error("serial index did not restart at input 0");

  AST_LAT_EIGHT: assert property (@(posedge clk_int) disable iff (reset_act)
    slow_edge && i_width_eight |=> load_word || !i_width_eight)
    else $error("width 8 load not one edge after slow edge");

  AST_LAT_FOUR: assert property (@(posedge clk_int) disable iff (reset_act)
    slow_edge && !i_width_eight |-> load_word)
    else $error("width 4 load not on slow edge");

  AST_DATA_BYPASS: assert property (@(posedge clk_int) disable iff (reset_act)
    i_data_path_bypass |=> o_serial_output == $past(data_s2_reg[0]))
    else $error("bypass output does not follow input 0");

  AST_SERIAL_ORDER: assert property (@(posedge clk_int) disable iff (reset_act)
    !i_data_path_bypass && !i_ddr_register_emulation && active_reg
    |=> o_serial_output == $past(word_reg[bit_cnt_reg]))
    else $error("serial bit out of order");

  AST_EMU_HIGH: assert property (@(posedge clk_int) disable iff (reset_act)
    !i_data_path_bypass && i_ddr_register_emulation && active_reg && upper_half
    |=> o_serial_output == $past(word_reg[4]))
    else $error("emulation second half not input 4");

  AST_HIZ_SERIAL: assert property (@(posedge clk_int) disable iff (reset_act)
    !i_hiz_path_bypass && i_ddr_register_emulation && !upper_half
    |=> o_hiz_output == $past(word_reg[1]))
    else $error("tristate first half not input 1");

  AST_HIZ_PLAIN: assert property (@(posedge clk_int) disable iff (reset_act)
    !i_hiz_path_bypass && !i_ddr_register_emulation
    |=> o_hiz_output == $past(hiz_s2_reg))
    else $error("tristate does not follow control input");

  AST_CNT_BOUND: assert property (@(posedge clk_int) disable iff (reset_act)
    $stable(i_width_eight) && active_reg |-> bit_cnt_reg <= last_idx)
    else $error("bit index beyond width");

  // Index and latency: a load on the edge itself would give both widths one latency
  AST_LAT_EIGHT_LATE: assert property (@(posedge clk_int) disable iff (reset_act)
    slow_edge && i_width_eight |-> !load_word)
    else $error("width 8 load came on the slow edge");

  // Index steps by one up to the last bit, where the counter holds
  AST_CNT_STEP: assert property (@(posedge clk_int) disable iff (reset_act)
    active_reg && !load_word && bit_cnt_reg != last_idx
    |=> bit_cnt_reg == $past(bit_cnt_reg) + 3'h1)
    else $error("serial index skipped an input");

  AST_IDLE_INIT: assert property (@(posedge clk_int) disable iff (reset_act)
    !i_data_path_bypass && !active_reg |=> o_serial_output == INIT_VALUE)
    else $error("output left initial value before first load");

  // Reduced paths: emulation halves and the tristate bypass
  AST_EMU_LOW: assert property (@(posedge clk_int) disable iff (reset_act)
    !i_data_path_bypass && i_ddr_register_emulation && active_reg && !upper_half
    |=> o_serial_output == $past(word_reg[0]))
    else $error("emulation first half not input 0");

  AST_HIZ_UPPER: assert property (@(posedge clk_int) disable iff (reset_act)
    !i_hiz_path_bypass && i_ddr_register_emulation && upper_half
    |=> o_hiz_output == $past(word_reg[5]))
    else $error("tristate second half not input 5");

  AST_HIZ_BYPASS: assert property (@(posedge clk_int) disable iff (reset_act)
    i_hiz_path_bypass |=> o_hiz_output == $past(data_s2_reg[1]))
    else $error("tristate bypass does not follow input 1");

  // Main scenarios worth seeing at least once

  COV_WIDTH_EIGHT: cover property (@(posedge clk_int) disable iff (reset_act)
    i_width_eight && bit_cnt_reg == 3'h7);
  COV_WIDTH_FOUR: cover property (@(posedge clk_int) disable iff (reset_act)
    !i_width_eight && load_word ##4 load_word);
  COV_EMULATION: cover property (@(posedge clk_int) disable iff (reset_act)
    i_ddr_register_emulation && active_reg && upper_half);
  COV_BYPASS: cover property (@(posedge clk_int) disable iff (reset_act)
    i_data_path_bypass && i_hiz_path_bypass && data_s2_reg[1]);

endmodule : pso_serializer
`default_nettype wire

// [pso_rx_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Receiver model beside the pad
// ****************************************
module pso_rx_model (
  // Clock
  input  wire logic       i_clock,
  // Pad side
  input  wire logic       i_serial,
  input  wire logic       i_hiz,
  // Assembled word
  output logic      [7:0] o_word
);
  logic line_bit;
  logic last_bit;

  // Released pad has no pull, so it shows the inverse of the last level to expose stale use
  assign line_bit = i_hiz ? ~last_bit : i_serial;

  // First bit received ends in the lowest position once a whole word has passed
  always_ff @(posedge i_clock)
  begin
    last_bit <= line_bit;
    o_word   <= {line_bit, o_word[7:1]};
  end
endmodule : pso_rx_model
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Serializer testbench
// ****************************************
module tb_top;
  // Design connections
  logic       i_clock;
  logic       i_reset;
  logic       i_slow_parallel_clock;
  logic [7:0] i_parallel_data;
  logic       i_hiz_control;
  logic       i_width_eight;
  logic       i_data_path_bypass;
  logic       i_hiz_path_bypass;
  logic       i_ddr_register_emulation;
  logic       o_serial_output;
  logic       o_hiz_output;
  logic [7:0] rx_word;
  int         n_fail;
  int         compares;

  pso_serializer pso_serializer_i (
    .i_clock                 (i_clock),
    .i_reset                 (i_reset),
    .i_slow_parallel_clock   (i_slow_parallel_clock),
    .i_parallel_data         (i_parallel_data),
    .i_hiz_control           (i_hiz_control),
    .i_width_eight           (i_width_eight),
    .i_data_path_bypass      (i_data_path_bypass),
    .i_hiz_path_bypass       (i_hiz_path_bypass),
    .i_ddr_register_emulation(i_ddr_register_emulation),
    .o_serial_output         (o_serial_output),
    .o_hiz_output            (o_hiz_output)
  );

  pso_rx_model pso_rx_model_i (
    .i_clock (i_clock),
    .i_serial(o_serial_output),
    .i_hiz   (o_hiz_output),
    .o_word  (rx_word)
  );

  // Fast clock, 4 ns period
  always #2 i_clock = ~i_clock;

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  // One word: data stable three cycles before a one-cycle slow pulse, then read the receiver
  task automatic run_word(input logic w8, input logic emu, input logic [7:0] d,
                          input logic [7:0] exp, input string name);
    logic [7:0] got;
    @(posedge i_clock);
    i_width_eight            <= w8;
    i_ddr_register_emulation <= emu;
    i_parallel_data          <= d;
    repeat (3) @(posedge i_clock);
    i_slow_parallel_clock <= 1'h1;
    @(posedge i_clock);
    i_slow_parallel_clock <= 1'h0;
    // Last bit is sampled by the receiver 13 or 8 edges after the slow rise
    repeat (w8 ? 12 : 7) @(posedge i_clock);
    #1;
    got = w8 ? rx_word : {4'h0, rx_word[7:4]};
    check(name, got, exp);
  endtask : run_word

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    i_clock                  = 1'h0;
    i_reset                  = 1'h1;
    i_slow_parallel_clock    = 1'h0;
    i_parallel_data          = 8'h00;
    i_hiz_control            = 1'h0;
    i_width_eight            = 1'h1;
    i_data_path_bypass       = 1'h0;
    i_hiz_path_bypass        = 1'h0;
    i_ddr_register_emulation = 1'h0;
    n_fail                   = 0;
    compares                 = 0;
    repeat (2) @(posedge i_clock);
    #1;
    check("reset serial", {7'h00, o_serial_output}, 8'(pso_pkg::INIT_VALUE_DEF));
    check("hiz in reset", {7'h00, o_hiz_output}, 8'h01);
    @(posedge i_clock);
    i_reset <= 1'h0;
    // Every documented width and ratio, wiring done by the driver
    run_word(1'h1, 1'h0, 8'hA5, 8'hA5, "ddr8 word");
    run_word(1'h0, 1'h0, 8'h0C, 8'h0C, "ddr4 word");
    run_word(1'h1, 1'h0, 8'hF3, 8'hF3, "sdr4 word");
    run_word(1'h0, 1'h0, 8'h03, 8'h03, "sdr2 word");
    run_word(1'h1, 1'h1, 8'h01, 8'h0F, "emul8 word");
    run_word(1'h0, 1'h1, 8'h10, 8'h0C, "emul4 word");
    // Reset in mid-run while the output rests high, then a clean restart
    run_word(1'h1, 1'h0, 8'hA5, 8'hA5, "ddr8 again");
    @(posedge i_clock);
    i_reset <= 1'h1;
    #1;
    check("async reset", {7'h00, o_serial_output}, {7'h00, pso_pkg::INIT_VALUE_DEF});
    @(posedge i_clock);
    i_reset <= 1'h0;
    run_word(1'h1, 1'h0, 8'h3C, 8'h3C, "after reset");
    // Tristate request, three cycles through the synchronisers
    @(posedge i_clock);
    i_hiz_control <= 1'h1;
    repeat (2) @(posedge i_clock);
    #1;
    check("hiz early", {7'h00, o_hiz_output}, 8'h00);
    @(posedge i_clock);
    #1;
    check("hiz set", {7'h00, o_hiz_output}, 8'h01);
    // Both bypass paths, opposite levels so a swap shows
    @(posedge i_clock);
    i_hiz_control      <= 1'h0;
    i_data_path_bypass <= 1'h1;
    i_hiz_path_bypass  <= 1'h1;
    i_parallel_data    <= 8'h01;
    repeat (4) @(posedge i_clock);
    #1;
    check("bypass one", {6'h00, o_serial_output, o_hiz_output}, 8'h02);
    @(posedge i_clock);
    i_parallel_data <= 8'h02;
    repeat (4) @(posedge i_clock);
    #1;
    check("bypass two", {6'h00, o_serial_output, o_hiz_output}, 8'h01);
    test_done();
  end

  // Watchdog, far beyond the 140 or so cycles the sequence needs
  initial
  begin
    repeat (2000) @(posedge i_clock);
    n_fail++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
